//--- shared/touch_pkg.sv
// Shared constants and types for the touch scan status sequencer.
package touch_pkg;
    // Channel space: 32 channels, pins 00..15 then 20..35
    localparam int NUM_CHANNELS = 32;
    localparam int CH_IDX_W = 5;
    localparam int PIN_NUM_W = 6;
    localparam logic [5:0] PIN_SPLIT_IDX = 6'h10;
    localparam logic [5:0] PIN_GAP = 6'h04;
    // Stabilisation and measurement counts, in operating-clock ticks
    localparam int TIME_CNT_W = 16;
    // Operating clock divider selections and terminal counts
    localparam logic [1:0] DIV_SEL_2 = 2'h0;
    localparam logic [1:0] DIV_SEL_4 = 2'h1;
    localparam logic [2:0] DIV_LIM_2 = 3'h1;
    localparam logic [2:0] DIV_LIM_4 = 3'h3;
    localparam logic [2:0] DIV_LIM_8 = 3'h7;
    localparam logic [2:0] DIV_RST = 3'h0;
    // Measurement modes
    localparam logic [1:0] MODE_SELF = 2'h0;
    localparam logic [1:0] MODE_MUTUAL = 2'h1;
    localparam logic [1:0] MODE_DC = 2'h2;
    // Scan mode select values
    localparam logic SCAN_SINGLE = 1'h0;
    localparam logic SCAN_MULTI = 1'h1;
    // Reset values
    localparam logic START_RST = 1'h0;
    localparam logic [CH_IDX_W-1:0] CH_RST = 5'h00;
    localparam logic [TIME_CNT_W-1:0] CNT_RST = 16'h0000;
    // Status counter, Gray coded along the scan path
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0, // Status 0
        ST_START  = 3'h1, // Status 1: pick channel
        ST_SETUP  = 3'h3, // Awaiting channel settings
        ST_STAB   = 3'h2, // Sensor stabilisation wait
        ST_MEAS   = 3'h6, // Measurement period
        ST_RDWAIT = 3'h7  // Awaiting result read
    } scan_state_t;
endpackage : touch_pkg

//--- shared/chan_pick_if.sv
// Interface between the sequencer and its next-channel picker.
interface chan_pick_if #(parameter int NUM_CH = 32, parameter int IDX_W = 5);
    logic [NUM_CH-1:0] mask;    // Channels eligible for this scan
    logic [IDX_W-1:0] from_idx; // Lowest index to consider
    logic from_valid;           // Low when no index is left to search
    logic found;                // An eligible channel exists
    logic [IDX_W-1:0] idx;      // Lowest eligible channel
    modport picker (input mask, input from_idx, input from_valid,
                    output found, output idx);
    modport user (output mask, output from_idx, output from_valid,
                  input found, input idx);
endinterface : chan_pick_if

//--- rtl/chan_picker.sv
// Finds the lowest eligible channel at or above a start index.
module chan_picker (
    chan_pick_if.picker pk
);
    localparam int N = $bits(pk.mask);
    localparam int W = $bits(pk.idx);
    logic [N-1:0] elig; // Mask bits at or above the start index

    // Qualify every bit against the start index
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_elig
            assign elig[g] = pk.mask[g] & pk.from_valid &
                             (W'(g) >= pk.from_idx);
        end
    endgenerate

    assign pk.found = |elig;

    // Priority encode, lowest index wins
    always_comb begin
        pk.idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (elig[i]) begin
                pk.idx = W'(i);
            end
        end
    end
endmodule // chan_picker

//--- rtl/touch_scan_status_sequencer.sv
// Status sequencer that runs a capacitive touch scan channel by channel.
// Notes on behaviour
// - Operating clock is system clock divided 2/4/8.
// - Up to 32 channels, pins 00-15, 20-35.
// - One status sequence for all three modes.
// - Status counter always shows current status.
// - Software trigger clears the start bit.
// - External trigger keeps start bit, awaits next.
// - Back to Status 0 after all channels.
// - Start 0 with init 1 forces stop.
// - Empty scan: Status 1, done, Status 0.
// - Empty when enable mask has no bit.
// - Single scan: empty if selected channel disabled.
// - Self mode: empty without any receive channel.
// - Mutual mode: empty lacking transmit or receive.
// - Setup, result read and done requests raised.
// - Mode bit 0 single channel, 1 all.
// - Drive starts only after channel settings written.
// - Read request after stabilisation and measurement.
module touch_scan_status_sequencer
    import touch_pkg::*;
#(
    parameter int NUM_CH = NUM_CHANNELS,
    parameter int CNT_W = TIME_CNT_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] clk_div_sel_i,
    input wire logic [1:0] meas_mode_i,
    input wire logic scan_mode_select_i,
    input wire logic ext_trig_sel_i,
    input wire logic [NUM_CH-1:0] channel_enable_mask_i,
    input wire logic [NUM_CH-1:0] channel_tx_rx_select_i,
    input wire logic [CH_IDX_W-1:0] single_scan_channel_select_i,
    input wire logic [CNT_W-1:0] stab_ticks_i,
    input wire logic [CNT_W-1:0] meas_ticks_i,
    input wire logic ctrl_write_i,
    input wire logic ctrl_start_wdata_i,
    input wire logic ctrl_init_wdata_i,
    input wire logic event_link_trigger_i,
    input wire logic setting_written_i,
    input wire logic result_read_i,
    output logic measure_start_bit_o,
    output logic [2:0] status_o,
    output logic [CH_IDX_W-1:0] channel_index_o,
    output logic [PIN_NUM_W-1:0] sense_pin_o,
    output logic drive_enable_o,
    output logic op_tick_o,
    output logic channel_setup_request_o,
    output logic result_read_request_o,
    output logic scan_done_irq_o
);
    scan_state_t state_q, state_d;     // Status counter
    logic [2:0] div_q;                 // Operating clock divider
    logic start_q, start_d;            // Measure start bit
    logic [CH_IDX_W-1:0] chan_q, chan_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;    // Stabilise / measure countdown
    logic setup_q, setup_d;            // One-cycle request pulses
    logic read_q, read_d;
    logic done_q, done_d;
    logic set_pend_q, rd_pend_q, trig_pend_q;
    logic [2:0] trig_sync_q;           // Trigger pin synchroniser
    logic trig_lvl_q;                  // Filtered trigger level

    // Decoded controls
    wire [2:0] div_lim = (clk_div_sel_i == DIV_SEL_2) ? DIV_LIM_2 :
                         (clk_div_sel_i == DIV_SEL_4) ? DIV_LIM_4 :
                         DIV_LIM_8;
    wire tick = (div_q >= div_lim);
    wire stop = ctrl_write_i & ~ctrl_start_wdata_i & ctrl_init_wdata_i;
    wire idle = (state_q == ST_IDLE);
    wire sw_go = idle & start_q & ~ext_trig_sel_i & tick;
    wire ext_go = idle & start_q & ext_trig_sel_i & trig_pend_q & tick;
    wire trig_agree = (trig_sync_q[1] == trig_sync_q[2]);
    wire trig_edge = trig_agree & trig_sync_q[1] & ~trig_lvl_q;
    wire last_chan = (chan_q == CH_IDX_W'(NUM_CH - 1));

    // Candidate channels per scan mode and measurement mode
    wire [NUM_CH-1:0] single_hot = NUM_CH'(1) << single_scan_channel_select_i;
    wire [NUM_CH-1:0] scope = (scan_mode_select_i == SCAN_SINGLE) ?
        (channel_enable_mask_i & single_hot) :
        channel_enable_mask_i;
    wire [NUM_CH-1:0] tx_set = channel_enable_mask_i & channel_tx_rx_select_i;
    wire [NUM_CH-1:0] rx_set = scope & ~channel_tx_rx_select_i;
    wire [NUM_CH-1:0] cand = (meas_mode_i == MODE_DC) ? scope : rx_set;
    // Mutual needs a transmitter as well; tx channels are not measured
    wire no_tx = (meas_mode_i == MODE_MUTUAL) & ~(|tx_set);
    wire empty = ~(|channel_enable_mask_i) | ~(|cand) | no_tx;

    // Next-channel search shared by scan start and every channel end
    chan_pick_if #(.NUM_CH(NUM_CH), .IDX_W(CH_IDX_W)) pick ();
    assign pick.mask = cand;
    assign pick.from_idx = (state_q == ST_START) ? CH_RST :
                           CH_IDX_W'(chan_q + 1'b1);
    assign pick.from_valid = (state_q == ST_START) | ~last_chan;
    chan_picker u_picker (
        .pk(pick)
    );

    // Divider: a tick marks each operating clock period
    always_ff @(posedge clk_i) begin
        if (!nrst_i) div_q <= DIV_RST;
        else if (tick) div_q <= DIV_RST;
        else div_q <= 3'(div_q + 1'b1);
    end

    // Trigger pin: three flops, level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            trig_sync_q <= 3'h0;
            trig_lvl_q <= 1'b0;
        end else begin
            trig_sync_q <= {trig_sync_q[1:0], event_link_trigger_i};
            if (trig_agree) trig_lvl_q <= trig_sync_q[1];
        end
    end

    // Pending answers; a new event beats the consuming clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i || stop) begin
            trig_pend_q <= 1'b0;
            set_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            // Triggers only count while idle with the start bit set
            trig_pend_q <= (trig_edge & idle & start_q) |
                           (trig_pend_q & ~ext_go & start_q);
            set_pend_q <= (setting_written_i & state_q == ST_SETUP) |
                          (set_pend_q & state_q == ST_SETUP);
            rd_pend_q <= (result_read_i & state_q == ST_RDWAIT) |
                         (rd_pend_q & state_q == ST_RDWAIT);
        end
    end

    // Start bit: write, software-trigger self clear, forced stop
    always_comb begin
        if (stop) start_d = 1'b0;
        else if (ctrl_write_i) start_d = ctrl_start_wdata_i;
        else if (sw_go) start_d = 1'b0;
        else start_d = start_q; // External trigger keeps it
    end

    // Status sequence, common to self, mutual and DC modes
    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        cnt_d = cnt_q;
        setup_d = 1'b0;
        read_d = 1'b0;
        done_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (sw_go || ext_go) state_d = ST_START;
            end
            ST_START: begin
                if (tick && empty) begin
                    state_d = ST_IDLE;
                    done_d = 1'b1;
                end else if (tick) begin
                    state_d = ST_SETUP;
                    chan_d = pick.idx;
                    setup_d = 1'b1;
                end
            end
            ST_SETUP: begin
                if (tick && set_pend_q) begin
                    state_d = ST_STAB;
                    cnt_d = stab_ticks_i;
                end
            end
            ST_STAB: begin
                if (tick && cnt_q == CNT_RST) begin
                    state_d = ST_MEAS;
                    cnt_d = meas_ticks_i;
                end else if (tick) begin
                    cnt_d = CNT_W'(cnt_q - 1'b1);
                end
            end
            ST_MEAS: begin
                if (tick && cnt_q == CNT_RST) begin
                    state_d = ST_RDWAIT;
                    read_d = 1'b1;
                end else if (tick) begin
                    cnt_d = CNT_W'(cnt_q - 1'b1);
                end
            end
            ST_RDWAIT: begin
                if (tick && rd_pend_q &&
                    scan_mode_select_i == SCAN_MULTI && pick.found) begin
                    state_d = ST_SETUP;
                    chan_d = pick.idx;
                    setup_d = 1'b1;
                end else if (tick && rd_pend_q) begin
                    state_d = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (stop) begin
            state_d = ST_IDLE;
            setup_d = 1'b0;
            read_d = 1'b0;
            done_d = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            start_q <= START_RST;
            chan_q <= CH_RST;
            cnt_q <= CNT_RST;
            {setup_q, read_q, done_q} <= 3'h0;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
            chan_q <= chan_d;
            cnt_q <= cnt_d;
            {setup_q, read_q, done_q} <= {setup_d, read_d, done_d};
        end
    end

    // Outputs; the pin number skips the gap between 15 and 20
    wire [PIN_NUM_W-1:0] chan_ext = PIN_NUM_W'(chan_q);
    assign sense_pin_o = (chan_ext >= PIN_SPLIT_IDX) ?
                         PIN_NUM_W'(chan_ext + PIN_GAP) : chan_ext;
    assign measure_start_bit_o = start_q;
    assign status_o = state_q;
    assign channel_index_o = chan_q;
    assign drive_enable_o = (state_q == ST_STAB) | (state_q == ST_MEAS);
    assign op_tick_o = tick;
    assign channel_setup_request_o = setup_q;
    assign result_read_request_o = read_q;
    assign scan_done_irq_o = done_q;

    // Checks on the sequence
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_stop_write;
        ctrl_write_i && !ctrl_start_wdata_i && ctrl_init_wdata_i;
    endsequence
    sequence s_empty_start;
        state_q == ST_START && tick && empty && !stop;
    endsequence

    property p_forced_stop;
        s_stop_write |=> state_q == ST_IDLE && !start_q && !setup_q;
    endproperty
    a_forced_stop: assert property (p_forced_stop)
        else $error("forced stop did not return to idle");

    property p_sw_clear;
        sw_go && !ctrl_write_i |=> !start_q && state_q == ST_START;
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("software trigger left start bit set");

    property p_ext_keep;
        ext_go && !ctrl_write_i |=> start_q && state_q == ST_START;
    endproperty
    a_ext_keep: assert property (p_ext_keep)
        else $error("external trigger changed start bit");

    property p_empty_done;
        s_empty_start |=> done_q && state_q == ST_IDLE ##1 !done_q;
    endproperty
    a_empty_done: assert property (p_empty_done)
        else $error("empty scan did not end at once");

    property p_idle_quiet;
        idle && $past(idle) |-> !setup_q && !read_q;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("transfer request while idle");

    property p_drive_after_setup;
        $rose(drive_enable_o) |-> $past(state_q) == ST_SETUP &&
                                  $past(set_pend_q);
    endproperty
    a_drive_after_setup: assert property (p_drive_after_setup)
        else $error("drive started before settings written");

    property p_read_after_meas;
        read_q |-> $past(state_q) == ST_MEAS && state_q == ST_RDWAIT;
    endproperty
    a_read_after_meas: assert property (p_read_after_meas)
        else $error("read request outside measurement end");

    property p_done_idle;
        done_q |-> idle && $past(state_q) != ST_IDLE;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("done without return to status 0");

    // Tick at t0, quiet at t1, tick again at t2 while /2 holds
    property p_div2_period;
        clk_div_sel_i == DIV_SEL_2 && tick ##1
            clk_div_sel_i == DIV_SEL_2 [*2] |-> tick && !$past(tick);
    endproperty
    a_div2_period: assert property (p_div2_period)
        else $error("divide by two period wrong");
endmodule // touch_scan_status_sequencer

//--- testbench/req_responder.sv
// Software-side model that answers the sequencer's data requests.
module req_responder (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] lag_i,
    input wire logic setup_req_i,
    input wire logic read_req_i,
    output logic setting_written_o,
    output logic result_read_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int wr_cnt; // Cycles left before settings are written
    int rd_cnt; // Cycles left before the result is read
    // Each request is answered once, lag_i cycles late, to mimic slow code
    always @(posedge clk_i) begin
        setting_written_o <= 1'b0;
        result_read_o <= 1'b0;
        if (!nrst_i) begin
            wr_cnt <= -1;
            rd_cnt <= -1;
        end else begin
            if (setup_req_i) begin
                wr_cnt <= int'(lag_i);
            end else if (wr_cnt > 0) begin
                wr_cnt <= wr_cnt - 1;
            end else if (wr_cnt == 0) begin
                setting_written_o <= 1'b1;
                wr_cnt <= -1;
            end
            if (read_req_i) begin
                rd_cnt <= int'(lag_i);
            end else if (rd_cnt > 0) begin
                rd_cnt <= rd_cnt - 1;
            end else if (rd_cnt == 0) begin
                result_read_o <= 1'b1;
                rd_cnt <= -1;
            end
        end
    end
endmodule // req_responder

//--- testbench/touch_scan_status_sequencer_test.sv
// Self-checking bench for the touch scan status sequencer.
module touch_scan_status_sequencer_test import touch_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, nrst_i = 0, multi = 1, ext_sel = 0, wr = 0, st = 0;
    logic ini = 0, trig = 0, set_wr, res_rd, start_bit, drive, tick;
    logic su_req, rd_req, done;
    logic [1:0] div_sel = 0, mode = 0;
    logic [31:0] en = 0, txrx = 0;
    logic [4:0] sel = 0, ch_idx;
    logic [15:0] stab = 0, meas = 0;
    logic [3:0] lag = 0;
    logic [2:0] status, prev_st;
    logic [5:0] pin;
    int errors = 0, compares = 0, done_cnt = 0, e, n;
    int exp_q[$]; // Channels the model expects, in visiting order
    bit pend = 0, saw1 = 0;
    touch_scan_status_sequencer touch_scan_status_sequencer_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .clk_div_sel_i(div_sel),
        .meas_mode_i(mode), .scan_mode_select_i(multi),
        .ext_trig_sel_i(ext_sel), .channel_enable_mask_i(en),
        .channel_tx_rx_select_i(txrx), .single_scan_channel_select_i(sel),
        .stab_ticks_i(stab), .meas_ticks_i(meas), .ctrl_write_i(wr),
        .ctrl_start_wdata_i(st), .ctrl_init_wdata_i(ini),
        .event_link_trigger_i(trig), .setting_written_i(set_wr),
        .result_read_i(res_rd), .measure_start_bit_o(start_bit),
        .status_o(status), .channel_index_o(ch_idx), .sense_pin_o(pin),
        .drive_enable_o(drive), .op_tick_o(tick),
        .channel_setup_request_o(su_req), .result_read_request_o(rd_req),
        .scan_done_irq_o(done));
    req_responder req_responder_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .lag_i(lag), .setup_req_i(su_req), .read_req_i(rd_req),
        .setting_written_o(set_wr), .result_read_o(res_rd));
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Reference model: eligible channels in rising index order
    task automatic plan_scan();
        bit tx_any;
        tx_any = |(en & txrx);
        exp_q = {};
        for (int i = 0; i < 32; i++) begin
            if (en[i] && (mode == MODE_DC || !txrx[i]) && (multi || sel == i)
                && (mode != MODE_MUTUAL || tx_any)) exp_q.push_back(i);
        end
    endtask
    task automatic write_ctrl(logic s, logic n_init);
        @(posedge clk_i);
        wr <= 1'b1;
        st <= s;
        ini <= n_init;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    // Bounded wait for one more end-of-scan pulse
    task automatic wait_done();
        n = done_cnt;
        for (int k = 0; k < 20000 && done_cnt == n; k++) @(posedge clk_i);
        check("done count", 1, done_cnt - n);
    endtask
    task automatic sw_scan();
        plan_scan();
        saw1 = 0;
        write_ctrl(1'b1, 1'b0);
        wait_done();
        check("start cleared", 0, start_bit);
        check("status 1 passed", 1, saw1);
    endtask
    task automatic fire();
        @(posedge clk_i);
        trig <= 1'b1;
        repeat (4) @(posedge clk_i);
        trig <= 1'b0;
    endtask
    // Monitor: each setup request is compared with the model as it appears
    always @(posedge clk_i) begin
        prev_st <= status;
        if (status === 3'h1) saw1 = 1;
        if (su_req === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 99;
            check("channel", e, 32'(ch_idx));
            check("pin", e < 16 ? e : e + 4, 32'(pin));
            check("setup status", 3, 32'(status));
            pend = 1;
        end
        if (set_wr === 1'b1) pend = 0;
        if (drive === 1'b1) check("drive gated", 0, 32'(pend));
        if (rd_req === 1'b1) begin
            check("read status", 7, 32'(status));
            check("measured before read", 6, 32'(prev_st));
        end
        if (done === 1'b1) begin
            done_cnt++;
            check("done status", 0, 32'(status));
            check("channels left", 0, exp_q.size());
        end
    end
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Watchdog sized well above the expected run length
    initial begin
        #200000;
        errors++;
        print_verdict();
    end
    initial begin
        logic [31:0] e_en[4] = '{32'h0000_0000, 32'h0000_00f0,
                                 32'h0000_ffff, 32'h0000_ffff};
        logic [31:0] e_tr[4] = '{32'h0000_0000, 32'h0000_0000,
                                 32'h0000_ffff, 32'h0000_0000};
        int cnt;
        void'($urandom(32'hfc24));
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        // Operating tick rate for every divider code
        for (int d = 0; d < 4; d++) begin
            @(posedge clk_i);
            div_sel <= 2'(d);
            repeat (20) @(posedge clk_i);
            cnt = 0;
            repeat (64) begin
                @(posedge clk_i);
                if (tick === 1'b1) cnt++;
            end
            check("ticks", d == 0 ? 32 : (d == 1 ? 16 : 8), cnt);
        end
        $display("Test divider done");
        // Random scans across all modes, single and multi
        for (int t = 0; t < 9; t++) begin
            @(posedge clk_i);
            mode <= 2'(t % 4);
            div_sel <= 2'($urandom_range(3));
            multi <= 1'($urandom);
            en <= $urandom & $urandom;
            txrx <= $urandom;
            sel <= 5'($urandom);
            stab <= 16'($urandom_range(3));
            meas <= 16'($urandom_range(3));
            lag <= 4'($urandom);
            @(posedge clk_i);
            sw_scan();
        end
        $display("Test random scans done");
        // Scans with nothing to measure
        for (int t = 0; t < 4; t++) begin
            @(posedge clk_i);
            en <= e_en[t];
            txrx <= e_tr[t];
            mode <= t == 3 ? MODE_MUTUAL : MODE_SELF;
            multi <= t != 1;
            sel <= 5'h02;
            @(posedge clk_i);
            sw_scan();
        end
        $display("Test empty scans done");
        // External trigger keeps the start bit and rearms
        @(posedge clk_i);
        ext_sel <= 1'b1;
        mode <= MODE_DC;
        en <= 32'h0003_0005;
        multi <= SCAN_MULTI;
        @(posedge clk_i);
        repeat (2) begin
            plan_scan();
            if (start_bit !== 1'b1) write_ctrl(1'b1, 1'b0);
            n = done_cnt;
            repeat (10) @(posedge clk_i);
            check("no trigger yet", n, done_cnt);
            check("awaiting trigger", 0, status);
            fire();
            wait_done();
            check("start kept", 1, start_bit);
        end
        n = done_cnt;
        write_ctrl(1'b0, 1'b1);
        @(posedge clk_i);
        check("stop status", 0, status);
        check("stop start", 0, start_bit);
        fire();
        repeat (40) @(posedge clk_i);
        check("idle ignores trigger", n, done_cnt);
        $display("Test external trigger done");
        // Forced stop in the middle of a measurement
        @(posedge clk_i);
        ext_sel <= 1'b0;
        div_sel <= DIV_SEL_2;
        stab <= 16'h00c8;
        meas <= 16'h00c8;
        @(posedge clk_i);
        plan_scan();
        write_ctrl(1'b1, 1'b0);
        for (int k = 0; k < 3000 && status !== 3'h6; k++) @(posedge clk_i);
        check("measuring", 6, status);
        n = done_cnt;
        write_ctrl(1'b0, 1'b1);
        exp_q = {};
        @(posedge clk_i);
        check("abort status", 0, status);
        check("abort drive", 0, drive);
        repeat (60) @(posedge clk_i);
        check("no done after abort", n, done_cnt);
        // Full set-up again before restarting
        stab <= 16'h0001;
        meas <= 16'h0002;
        en <= 32'h8000_0001;
        @(posedge clk_i);
        sw_scan();
        $display("Test forced stop done");
        print_verdict();
    end
endmodule // touch_scan_status_sequencer_test
